// file: adc_capture_model.sv
`timescale 1ns/1ps
`default_nettype none
module adc_capture_model (
  // clock and pins of the shared lanes
  input  wire logic                   i_clk,
  input  wire logic                   i_dco,
  input  wire adc_clk_pkg::lane_pair_t i_lane,
  input  wire logic                   i_oe,
  // rebuilt four-channel word
  output var  adc_clk_pkg::quad_smp_t o_word
);
  import adc_clk_pkg::*;
  // --------------------------------------------
  // capture register on the far side
  // --------------------------------------------
  lane_pair_t last_r;   // level last seen on the pins
  lane_pair_t rise_r;   // a/c half held until b/d comes
  lane_pair_t pin_lvl;  // released lanes drift, no pull
  assign pin_lvl = i_oe ? i_lane : ~last_r;
  // mid-phase sampling keeps clear of the launch edge
  always_ff @(negedge i_clk) begin
    last_r <= pin_lvl;
    if (i_dco) begin
      rise_r <= pin_lvl;
    end else begin
      o_word <= {rise_r.ab, pin_lvl.ab, rise_r.cd, pin_lvl.cd};
    end
  end
endmodule
`default_nettype wire

// file: adc_clk_pkg.sv
// Contract
// R01 - divide sample clock by one to eight
// R02 - bit one of 0x3A enables resync
// R03 - align event returns divider to start
// R04 - align input double-synchronised before use
// R05 - stabilizer regenerates falling edge, half duty; odd ratios are high (ratio+1)/2 counts
// R06 - stabilizer inactive below forty megahertz
// R07 - controller waits 1.5 to 5 us relock
// R08 - unlocked stabilizer is bypassed
// R09 - samples emerge nine clock cycles later
// R10 - pin or register enters power-down
// R11 - output drivers high impedance when down
// R12 - down stops clock; wake time grows
// R13 - register standby keeps reference, faster wake
// R14 - first and third channel on rise
// R15 - second and fourth channel on fall
// R16 - output coding selectable by register
// R17 - offset binary; twos inverts msb
// R18 - sample on internal clock rising edge
// R19 - ratio field defaults one, safe change
package adc_clk_pkg;
  // --------------------------------------------------
  // datapath shapes
  // --------------------------------------------------
  localparam int SMP_W    = 16;   // code width
  localparam int DIV_W    = 3;    // ratio minus one
  localparam int PIPE_LAT = 9;    // sample periods
  localparam int PDC_W    = 12;   // down-time counter
  typedef struct packed {
    logic [SMP_W-1:0] a, b, c, d;
  } quad_smp_t;
  typedef struct packed {
    logic [SMP_W-1:0] ab, cd;     // shared lanes
  } lane_pair_t;
  // --------------------------------------------------
  // register indices (byte address = 4 x index)
  // --------------------------------------------------
  localparam logic [7:0] IDX_CTRL = 8'h08;
  localparam logic [7:0] IDX_PWR  = 8'h09;
  localparam logic [7:0] IDX_STAT = 8'h0B;
  localparam logic [7:0] IDX_FMT  = 8'h14;
  localparam logic [7:0] IDX_SYNC = 8'h3A;
  // field positions
  localparam int CTRL_DIV_LSB  = 0;
  localparam int CTRL_DCS_BIT  = 4;
  localparam int CTRL_FAST_BIT = 5;
  localparam int PWR_PD_BIT    = 0;
  localparam int PWR_STBY_BIT  = 1;
  localparam int FMT_TWOS_BIT  = 0;
  localparam int SYNC_RES_BIT  = 1;
  // reset values
  localparam logic [7:0] CTRL_RST = 8'h10;  // div 1, stabilizer on
  localparam logic [7:0] PWR_RST  = 8'h00;
  localparam logic [7:0] FMT_RST  = 8'h00;
  localparam logic [7:0] SYNC_RST = 8'h00;
  // --------------------------------------------------
  // timing
  // --------------------------------------------------
  localparam int CLK_NS        = 50;
  localparam int DCS_LOCK_NS   = 1500;
  localparam int DCS_LOCK_CYC  = (DCS_LOCK_NS + CLK_NS - 1) / CLK_NS;
  localparam int STBY_WAKE_CYC = 4;
  // power states, one-hot
  typedef enum logic [3:0] {
    PS_RUN  = 4'b0001,
    PS_DOWN = 4'b0010,
    PS_STBY = 4'b0100,
    PS_WAKE = 4'b1000
  } pwr_st_t;
endpackage

// file: adc_clk_port.sv
// The placing of the registers and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module adc_clk_port (
  // clock and reset
  input  wire logic                    I_REF_CLK,
  input  wire logic                    I_SYS_RST,
  // board side
  input  wire logic                    I_ALIGN,
  input  wire logic                    I_POWER_DOWN_PIN,
  input  wire adc_clk_pkg::quad_smp_t  I_SMP,
  // capture side
  output logic                         O_DATA_CLOCK_OUTPUT,
  output adc_clk_pkg::lane_pair_t      O_LANE,
  output logic                         O_LANE_OE,
  output logic                         O_DIV_CLK,
  // axi4-lite write
  input  wire logic [9:0]              I_AWADDR,
  input  wire logic                    I_AWVALID,
  output logic                         O_AWREADY,
  input  wire logic [31:0]             I_WDATA,
  input  wire logic [3:0]              I_WSTRB,
  input  wire logic                    I_WVALID,
  output logic                         O_WREADY,
  output logic [1:0]                   O_BRESP,
  output logic                         O_BVALID,
  input  wire logic                    I_BREADY,
  // axi4-lite read
  input  wire logic [9:0]              I_ARADDR,
  input  wire logic                    I_ARVALID,
  output logic                         O_ARREADY,
  output logic [31:0]                  O_RDATA,
  output logic [1:0]                   O_RRESP,
  output logic                         O_RVALID,
  input  wire logic                    I_RREADY
);
  import adc_clk_pkg::*;
  // --------------------------------------------------
  // declarations
  // --------------------------------------------------
  logic [7:0]       ctrl_r, pwr_r, fmt_r, sync_r;  // config
  logic [9:0]       awa_r;                          // held write addr
  logic [7:0]       wd_r;                           // held write byte
  logic             wstb_r;                         // lane 0 enabled
  logic             aw_full_r, w_full_r, do_wr;
  logic [DIV_W-1:0] div_f, cnt_r, cnt_n;            // divider
  logic             run, ev, smp_stb, resync_en;
  logic             al_s1_r, al_s2_r, al_s3_r;      // align sync
  logic [5:0]       dcs_cnt_r;                      // relock timer
  logic             lock;
  pwr_st_t          ps_r, ps_n;
  logic [PDC_W-1:0] down_cnt_r, wake_cnt_r;
  logic             pd_req, stby_req;
  quad_smp_t        pipe_r [PIPE_LAT];              // latency line
  quad_smp_t        word_f;
  logic [2*SMP_W-1:0] bd_r;                         // held b and d
  logic             phase_r;
  assign div_f     = ctrl_r[CTRL_DIV_LSB +: DIV_W];
  assign resync_en = sync_r[SYNC_RES_BIT];
  assign pd_req    = I_POWER_DOWN_PIN | pwr_r[PWR_PD_BIT]; // R10
  assign stby_req  = pwr_r[PWR_STBY_BIT];
  assign run       = (ps_r == PS_RUN);
  assign lock      = (dcs_cnt_r == 6'(DCS_LOCK_CYC));
  // map a byte address to a register index
  function automatic logic [7:0] idx_of(input logic [9:0] a);
    return a[9:2];
  endfunction
  // msb flip selects twos complement coding
  function automatic quad_smp_t fmt(input quad_smp_t x, input logic tw);
    quad_smp_t y;
    logic [SMP_W-1:0] m;
    m = {tw, {(SMP_W-1){1'b0}}};
    y = '{a: x.a ^ m, b: x.b ^ m, c: x.c ^ m, d: x.d ^ m};
    return y;
  endfunction

  // --------------------------------------------------
  // axi4-lite write channel
  // --------------------------------------------------
  // address and data taken in either order; commit when both held
  assign do_wr = aw_full_r & w_full_r & ~O_BVALID;
  always_ff @(posedge I_REF_CLK) begin
    if (I_SYS_RST) begin
      aw_full_r <= 1'b0;
      w_full_r  <= 1'b0;
      O_AWREADY <= 1'b1;
      O_WREADY  <= 1'b1;
      awa_r     <= 10'h000;
      wd_r      <= 8'h00;
      wstb_r    <= 1'b0;
    end else begin
      // address slot
      if (do_wr) begin
        aw_full_r <= 1'b0;
        O_AWREADY <= 1'b1;
      end else if (I_AWVALID & O_AWREADY) begin
        aw_full_r <= 1'b1;
        O_AWREADY <= 1'b0;
        awa_r     <= I_AWADDR;
      end
      // data slot, only the low byte carries bits
      if (do_wr) begin
        w_full_r <= 1'b0;
        O_WREADY <= 1'b1;
      end else if (I_WVALID & O_WREADY) begin
        w_full_r <= 1'b1;
        O_WREADY <= 1'b0;
        wd_r     <= I_WDATA[7:0];
        wstb_r   <= I_WSTRB[0];
      end
    end
  end
  // response and register update
  always_ff @(posedge I_REF_CLK) begin
    if (I_SYS_RST) begin
      O_BVALID <= 1'b0;
      O_BRESP  <= 2'b00;
      ctrl_r   <= CTRL_RST; // R19
      pwr_r    <= PWR_RST;
      fmt_r    <= FMT_RST;
      sync_r   <= SYNC_RST;
    end else begin
      if (do_wr) begin
        O_BVALID <= 1'b1;
        O_BRESP  <= 2'b00;
        case (idx_of(awa_r))
          IDX_CTRL: if (wstb_r) ctrl_r <= wd_r; // R01
          IDX_PWR:  if (wstb_r) pwr_r  <= wd_r; // R13
          IDX_FMT:  if (wstb_r) fmt_r  <= wd_r; // R16
          IDX_SYNC: if (wstb_r) sync_r <= wd_r; // R02
          IDX_STAT: O_BRESP <= 2'b00;           // read-only, write dropped
          default:  O_BRESP <= 2'b10;           // unmapped
        endcase
      end else if (O_BVALID & I_BREADY) begin
        O_BVALID <= 1'b0;
      end
    end
  end

  // --------------------------------------------------
  // axi4-lite read channel
  // --------------------------------------------------
  always_ff @(posedge I_REF_CLK) begin
    if (I_SYS_RST) begin
      O_ARREADY <= 1'b1;
      O_RVALID  <= 1'b0;
      O_RDATA   <= 32'h0000_0000;
      O_RRESP   <= 2'b00;
    end else if (I_ARVALID & O_ARREADY) begin
      O_ARREADY <= 1'b0;
      O_RVALID  <= 1'b1;
      O_RRESP   <= 2'b00;
      case (idx_of(I_ARADDR))
        IDX_CTRL: O_RDATA <= {24'h00_0000, ctrl_r};
        IDX_PWR:  O_RDATA <= {24'h00_0000, pwr_r};
        IDX_FMT:  O_RDATA <= {24'h00_0000, fmt_r};
        IDX_SYNC: O_RDATA <= {24'h00_0000, sync_r};
        // live state: lock, run, power state, divider phase
        IDX_STAT: O_RDATA <= {22'h0_0000, cnt_r, ps_r, run, lock};
        default: begin
          O_RDATA <= 32'h0000_0000;
          O_RRESP <= 2'b10;
        end
      endcase
    end else if (O_RVALID & I_RREADY) begin
      O_RVALID  <= 1'b0;
      O_ARREADY <= 1'b1;
    end
  end

  // --------------------------------------------------
  // align input synchroniser
  // --------------------------------------------------
  // the second and third stages feed the edge detector
  always_ff @(posedge I_REF_CLK) begin
    if (I_SYS_RST) begin
      al_s1_r <= 1'b0;
      al_s2_r <= 1'b0;
      al_s3_r <= 1'b0;
    end else begin
      al_s1_r <= I_ALIGN; // R04
      al_s2_r <= al_s1_r;
      al_s3_r <= al_s2_r;
    end
  end
  assign ev = al_s2_r & ~al_s3_r & resync_en; // R02
  // --------------------------------------------------
  // integer divider
  // --------------------------------------------------
  // wrap on >= so a smaller ratio never strands the count
  always_comb begin
    if (!run)
      cnt_n = '0;                        // R12
    else if (ev)
      cnt_n = '0;                        // R03
    else if (cnt_r >= div_f)
      cnt_n = '0;                        // R19
    else
      cnt_n = cnt_r + 3'h1;              // R01
  end
  assign smp_stb = run & (cnt_r == '0);   // R18
  always_ff @(posedge I_REF_CLK) begin
    if (I_SYS_RST) begin
      cnt_r     <= '0;
      O_DIV_CLK <= 1'b0;
    end else begin
      cnt_r <= cnt_n;
      // locked: high for the first (ratio+1)/2 counts; bypass: one source pulse per period
      if (lock)
        O_DIV_CLK <= ({1'b0, cnt_n} < ({1'b0, div_f} + 4'h2) >> 1); // R05
      else
        O_DIV_CLK <= run & (cnt_n == '0);                          // R08
    end
  end

  // --------------------------------------------------
  // duty-cycle stabilizer lock model
  // --------------------------------------------------
  // any ratio or rate change restarts the relock wait
  always_ff @(posedge I_REF_CLK) begin
    if (I_SYS_RST) begin
      dcs_cnt_r <= '0;
    end else if (!run || !ctrl_r[CTRL_DCS_BIT] || !ctrl_r[CTRL_FAST_BIT]) begin
      dcs_cnt_r <= '0;                                           // R06
    end else if (do_wr && idx_of(awa_r) == IDX_CTRL && wstb_r && wd_r != ctrl_r) begin
      dcs_cnt_r <= '0;                                           // R07
    end else if (!lock) begin
      dcs_cnt_r <= dcs_cnt_r + 6'h01;
    end
  end

  // --------------------------------------------------
  // power control
  // --------------------------------------------------
  always_comb begin
    case (ps_r)
      PS_RUN:  ps_n = pd_req ? PS_DOWN : (stby_req ? PS_STBY : PS_RUN);
      PS_DOWN: ps_n = pd_req ? PS_DOWN : PS_WAKE;             // R10
      PS_STBY: ps_n = pd_req ? PS_DOWN : (stby_req ? PS_STBY : PS_WAKE);
      PS_WAKE: ps_n = pd_req ? PS_DOWN : (wake_cnt_r == '0 ? PS_RUN : PS_WAKE);
      default: ps_n = PS_DOWN;
    endcase
  end

  always_ff @(posedge I_REF_CLK) begin
    if (I_SYS_RST) begin
      ps_r       <= PS_RUN;
      down_cnt_r <= '0;
      wake_cnt_r <= '0;
      O_LANE_OE  <= 1'b1;
    end else begin
      ps_r      <= ps_n;
      O_LANE_OE <= (ps_n != PS_DOWN);                          // R11
      if (ps_r == PS_DOWN) begin
        if (down_cnt_r != '1)
          down_cnt_r <= down_cnt_r + 12'h001;                  // R12
      end else begin
        down_cnt_r <= '0;
      end
      // wake time tracks time down; standby is short and fixed
      if (ps_r == PS_DOWN && ps_n == PS_WAKE)
        wake_cnt_r <= down_cnt_r;                              // R12
      else if (ps_r == PS_STBY && ps_n == PS_WAKE)
        wake_cnt_r <= PDC_W'(STBY_WAKE_CYC);                   // R13
      else if (wake_cnt_r != '0)
        wake_cnt_r <= wake_cnt_r - 12'h001;
    end
  end

  // --------------------------------------------------
  // latency line and output coding
  // --------------------------------------------------
  always_ff @(posedge I_REF_CLK) begin
    if (I_SYS_RST) begin
      for (int i = 0; i < PIPE_LAT; i++)
        pipe_r[i] <= '0;
    end else if (smp_stb) begin
      pipe_r[0] <= I_SMP;                                      // R18
      for (int i = 1; i < PIPE_LAT; i++)
        pipe_r[i] <= pipe_r[i-1];                              // R09
    end
  end
  assign word_f = fmt(pipe_r[PIPE_LAT-1], fmt_r[FMT_TWOS_BIT]); // R17
  // --------------------------------------------------
  // ddr lanes
  // --------------------------------------------------
  // edge-aligned: lane and clock change on the same edge
  always_ff @(posedge I_REF_CLK) begin
    if (I_SYS_RST) begin
      phase_r             <= 1'b0;
      O_DATA_CLOCK_OUTPUT <= 1'b0;
      O_LANE              <= '0;
      bd_r                <= '0;
    end else begin
      phase_r <= ~phase_r;
      if (!phase_r) begin
        O_DATA_CLOCK_OUTPUT <= 1'b1;
        O_LANE              <= '{ab: word_f.a, cd: word_f.c}; // R14
        bd_r                <= {word_f.b, word_f.d};
      end else begin
        O_DATA_CLOCK_OUTPUT <= 1'b0;
        O_LANE              <= bd_r;                          // R15
      end
    end
  end

  // --------------------------------------------------
  // checks
  // --------------------------------------------------
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (I_SYS_RST);
  sequence s_align_edge;
    al_s2_r && !al_s3_r && resync_en && run;
  endsequence
  sequence s_stby_exit;
    ps_r == PS_STBY && !stby_req && !pd_req;
  endsequence
  chk_div_range: assert property (cnt_r <= div_f || $changed(div_f) || $past(div_f) != div_f)  // R01
    else $error("divider count beyond ratio");
  chk_align_reset: assert property (s_align_edge |=> cnt_r == '0 ##1 (cnt_r == '0 || smp_stb == 1'b0 || cnt_r == 3'h1))  // R03
    else $error("align event did not restart divider");
  chk_sync_delay: assert property (ev |-> $past(I_ALIGN, 2) && !$past(I_ALIGN, 3))  // R04
    else $error("align event not two stages late");
  chk_dcs_bypass: assert property (!lock && run |=> O_DIV_CLK == (cnt_r == '0))  // R08
    else $error("unlocked divider output not bypassed");
  chk_dcs_slow: assert property (!ctrl_r[CTRL_FAST_BIT] |-> !lock)  // R06
    else $error("stabilizer locked on slow clock");
  chk_pipe_shift: assert property (smp_stb |=> pipe_r[0] == $past(I_SMP) && pipe_r[8] == $past(pipe_r[7]))  // R09
    else $error("latency line did not advance");
  chk_down_hiz: assert property (pd_req |=> !O_LANE_OE ##1 cnt_r == '0)  // R11
    else $error("drivers active in power-down");
  chk_dco_rise: assert property ($rose(O_DATA_CLOCK_OUTPUT) |-> O_LANE.ab == $past(word_f.a))  // R14
    else $error("channel a not on rising edge");
  chk_dco_fall: assert property ($fell(O_DATA_CLOCK_OUTPUT) |-> O_LANE == $past(bd_r))  // R15
    else $error("channels b,d not on falling edge");
  chk_fmt_msb: assert property (word_f.a[SMP_W-1] == (pipe_r[8].a[SMP_W-1] ^ fmt_r[FMT_TWOS_BIT]))  // R17
    else $error("output coding msb wrong");
  chk_stby_wake: assert property (s_stby_exit |=> ps_r == PS_WAKE ##[1:6] ps_r == PS_RUN)  // R13
    else $error("standby wake too slow");
endmodule
`default_nettype wire

// file: tb_adc_clock_sync_output_port.sv
`timescale 1ns/1ps
`default_nettype none
module tb_adc_clock_sync_output_port;
  import adc_clk_pkg::*;
  // --------------------------------------------
  // nets, rows and counters
  // --------------------------------------------
  typedef struct packed { logic [7:0] ctrl; int edges; int highs; } row_t;
  // window of 840 clocks holds whole periods of every ratio
  localparam row_t rows [9] = '{'{8'h30, 0, 840}, '{8'h31, 420, 420}, '{8'h32, 280, 560},
    '{8'h33, 210, 420}, '{8'h34, 168, 504}, '{8'h37, 105, 420}, '{8'h17, 105, 105},
    '{8'h16, 120, 120}, '{8'h25, 140, 140}};
  localparam quad_smp_t smp_init = 64'h1234_5678_9abc_def0;
  localparam quad_smp_t smp_edge = 64'h0000_8000_ffff_7fff; // scale ends
  localparam logic [7:0] zidx [3] = '{IDX_PWR, IDX_FMT, IDX_SYNC};
  logic        clk, rst, align, pdp, awv, wv, arv, bready, rready;
  logic        awr, wr, arr, bv, rv, data_clock_output, oe, divc;
  logic [9:0]  awa, ara;
  logic [31:0] wd, rd, rdat;
  logic [1:0]  br, rr, resp;
  quad_smp_t   smp, word;
  lane_pair_t  lane;
  int          errors, comparisons, e, h, d1, d2, n;
  int          w [2];
  adc_clk_port i_dut (.I_REF_CLK(clk), .I_SYS_RST(rst), .I_ALIGN(align), .I_POWER_DOWN_PIN(pdp),
    .I_SMP(smp), .O_DATA_CLOCK_OUTPUT(data_clock_output), .O_LANE(lane), .O_LANE_OE(oe), .O_DIV_CLK(divc),
    .I_AWADDR(awa), .I_AWVALID(awv), .O_AWREADY(awr), .I_WDATA(wd), .I_WSTRB(4'hf), .I_WVALID(wv),
    .O_WREADY(wr), .O_BRESP(br), .O_BVALID(bv), .I_BREADY(bready), .I_ARADDR(ara), .I_ARVALID(arv),
    .O_ARREADY(arr), .O_RDATA(rd), .O_RRESP(rr), .O_RVALID(rv), .I_RREADY(rready));
  adc_capture_model i_cap (.i_clk(clk), .i_dco(data_clock_output), .i_lane(lane), .i_oe(oe), .o_word(word));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // --------------------------------------------
  // compare, bus and timing tasks
  // --------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chkw(input quad_smp_t got, input quad_smp_t exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: word %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // one edge first, so no strobe is set twice in one step
  task automatic wreg(input logic [7:0] idx, input logic [31:0] d);
    bit a_ok;
    bit w_ok;
    @(posedge clk);
    awa <= {idx, 2'b00};
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    a_ok = 0;
    w_ok = 0;
    while (!(a_ok && w_ok)) begin
      @(posedge clk);
      if (awv && awr) begin
        a_ok = 1;
        awv <= 1'b0;
      end
      if (wv && wr) begin
        w_ok = 1;
        wv <= 1'b0;
      end
    end
    do @(posedge clk); while (!bv);
    resp = br;
    bready <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] idx);
    @(posedge clk);
    ara <= {idx, 2'b00};
    arv <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (!arr);
    arv <= 1'b0;
    do @(posedge clk); while (!rv);
    rdat = rd;
    resp = rr;
    rready <= 1'b0;
  endtask
  // clocks until the divided clock next rises
  task automatic wait_rise(output int cnt);
    logic p;
    p = divc;
    cnt = 0;
    forever begin
      @(posedge clk);
      cnt++;
      if (divc && !p) break;
      p = divc;
    end
  endtask
  task automatic align_at(input int pre, output int d);
    wait_rise(d);
    repeat (pre) @(posedge clk);
    align <= 1'b1;
    repeat (4) @(posedge clk);
    align <= 1'b0;
    wait_rise(d);
  endtask
  task automatic measure(output int ed, output int hi);
    logic p;
    p = divc;
    ed = 0;
    hi = 0;
    repeat (840) begin
      @(posedge clk);
      hi += divc;
      ed += (divc && !p);
      p = divc;
    end
  endtask
  // poll status until running again; granular to one read
  task automatic wake(output int cyc);
    time t0;
    t0 = $time;
    do rreg(IDX_STAT); while (rdat[1] !== 1'b1);
    cyc = int'(($time - t0) / 50);
  endtask
  // --------------------------------------------
  // main sequence and watchdog
  // --------------------------------------------
  initial begin
    {rst, align, pdp, awv, wv, arv, bready, rready} = 8'h80;
    {awa, ara, wd} = '0;
    smp = smp_init;
    errors = 0;
    comparisons = 0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rreg(IDX_CTRL);
    chk(rdat, {24'h0, CTRL_RST});
    foreach (zidx[i]) begin
      rreg(zidx[i]);
      chk(rdat, 32'h0);
    end
    wreg(8'hff, 32'h1);
    chk(resp, 2'b10);
    rreg(8'hff);
    chk({rdat[29:0], resp}, 32'h2);
    // ratio, stabilizer and lock table
    foreach (rows[i]) begin
      wreg(IDX_CTRL, {24'h0, rows[i].ctrl});
      rreg(IDX_CTRL);
      chk(rdat, {24'h0, rows[i].ctrl});
      repeat (40) @(posedge clk);
      rreg(IDX_STAT);
      chk(rdat[0], rows[i].ctrl[5] & rows[i].ctrl[4]);
      measure(e, h);
      chk(e, rows[i].edges);
      chk(h, rows[i].highs);
    end
    // align phases differ by two clocks; only resync evens them
    for (int s = 0; s < 2; s++) begin
      wreg(IDX_SYNC, s ? 32'h2 : 32'h0);
      align_at(0, d1);
      align_at(2, d2);
      chk(d1 == d2, s);
    end
    wreg(IDX_CTRL, 32'h10);
    repeat (30) @(posedge clk);
    chkw(word, smp_init);
    smp <= smp_edge;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (word !== smp_edge && n < 40);
    chk(n >= 12 && n <= 13, 1);
    wreg(IDX_FMT, 32'h1);
    repeat (30) @(posedge clk);
    chkw(word, smp_edge ^ 64'h8000_8000_8000_8000);
    wreg(IDX_FMT, 32'h0);
    // longer time down must mean a longer wake
    for (int k = 0; k < 2; k++) begin
      pdp <= 1'b1;
      repeat (3) @(posedge clk);
      chk(oe, 1'b0);
      rreg(IDX_STAT);
      chk(rdat[5:2], 4'b0010);
      repeat (k ? 200 : 20) @(posedge clk);
      pdp <= 1'b0;
      wake(w[k]);
      chk(oe, 1'b1);
    end
    chk(w[0] >= 20 && w[0] < 60 && w[1] >= 200 && w[1] < 260, 1);
    wreg(IDX_PWR, 32'h1);
    repeat (2) @(posedge clk);
    chk(oe, 1'b0);
    wreg(IDX_PWR, 32'h0);
    wake(n);
    wreg(IDX_PWR, 32'h2);
    rreg(IDX_STAT);
    chk({rdat[5:0], oe}, 7'b0100001);
    repeat (200) @(posedge clk);
    wreg(IDX_PWR, 32'h0);
    wake(n);
    chk(n <= 12, 1);
    // reset again in mid-run
    wreg(IDX_FMT, 32'h1);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rreg(IDX_FMT);
    chk(rdat, 32'h0);
    end_of_test();
  end
  initial begin
    repeat (30000) @(posedge clk);
    errors++;
    $display("mismatch at %0t: watchdog expired", $time);
    end_of_test();
  end
endmodule
`default_nettype wire
